//--- logic/ces_top.v
// Purpose: Cam engage sequencer: starts a follower tracking a leader through
//          a planned cam relation, with APB control and status.
// Assumes: 25 MHz control clock; leader position from another clock domain.
// Notes:   Cam relation is identity on phases (follower phase = leader
//          phase) scaled by the captured follower ratio; release is not handled.
//
// Implementation choices: the APB interface to the registers and the register offsets.
`include "ces_regs.vh"
`default_nettype none

module ces_top (
   // Clock and reset
   input  wire        sys_clk_i,
   input  wire        rst_n_i,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Leader axis position, asynchronous
   input  wire [31:0] leader_pos_i,
   // Follower drive
   output reg  [31:0] follower_pos_o,
   // Status
   output reg         busy_o,
   output reg         active_o,
   output reg         aborted_flag_o,
   output reg         error_o,
   output reg  [15:0] fault_code_o,
   output reg         profile_done_o,
   output reg         locked_flag_o
);

   // One-hot states
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_WAIT = 5'h02;
   localparam [4:0] ST_ENG  = 5'h04;
   localparam [4:0] ST_SYNC = 5'h08;
   localparam [4:0] ST_ERR  = 5'h10;

   // Software registers
   reg  [31:0] ctrl_r;
   reg  [31:0] mode_r;
   reg  [31:0] point_r;
   reg  [31:0] vlim_r;
   reg  [31:0] alim_r;
   reg  [31:0] dlim_r;
   reg  [31:0] modulus_r;
   reg  [31:0] cycle_r;
   reg  [31:0] lshift_r;
   reg  [31:0] fshift_r;
   reg  [31:0] lratio_r;
   reg  [31:0] fratio_r;

   // Held copies taken at start
   reg  [1:0]  h_mode_r;
   reg  [1:0]  h_dir_r;
   reg  [31:0] h_point_r;
   reg  [31:0] h_vlim_r;
   reg  [31:0] h_alim_r;
   reg  [31:0] h_dlim_r;
   reg  [31:0] h_modulus_r;
   reg  [31:0] h_cycle_r;
   reg         h_labs_r;
   reg         h_fabs_r;
   reg  [31:0] h_lshift_r;
   reg  [31:0] h_fshift_r;
   reg  [31:0] h_lratio_r;
   reg  [31:0] h_fratio_r;
   reg  [31:0] target_r;
   reg         armed_r;

   // Relation fixed at the engage instant
   reg  [31:0] lbase_r;
   reg  [31:0] fbase_r;

   reg  [4:0]  state_r;
   reg  [4:0]  state_nxt;
   reg         exec_d_r;
   reg  [31:0] lead_s1_r;
   reg  [31:0] lead_r;
   reg  [31:0] tgt_vel;
   reg  [31:0] err;
   reg  [31:0] fol_want;
   reg  [31:0] lead_ph;

   wire        exec_rise;
   wire        start;
   wire        point_hit;
   wire        direct;
   wire        ramp_halt;
   wire        ramp_run;
   wire [31:0] fol_pos;
   wire [31:0] fol_vel;
   wire [31:0] lead_mod;
   wire [31:0] lead_cam;
   wire        apb_wr;
   wire        apb_rd;

   assign apb_wr = psel && penable && pwrite && pready;
   assign apb_rd = psel && !penable && !pwrite;

   // Execute edge from the control register; a fall starts nothing
   assign exec_rise = ctrl_r[`CES_CTRL_EXEC_BIT] &&
                      !exec_d_r;
   // Busy states ignore a new edge unless policy 0 asks to restart
   assign start = exec_rise && (!busy_o ||
                  !ctrl_r[`CES_CTRL_RETRG_BIT]);

   // Leader position passes two flip-flops before use
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lead_s1_r <= `CES_POS_RESET;
         lead_r    <= `CES_POS_RESET;
         exec_d_r  <= 1'b0;
      end else begin
         lead_s1_r <= leader_pos_i;
         lead_r    <= lead_s1_r;
         exec_d_r  <= ctrl_r[`CES_CTRL_EXEC_BIT];
      end
   end

   // Leader phases over the held modulus and cam cycle
   assign lead_mod = (h_modulus_r == `CES_ZERO32) ? lead_r :
                     lead_r % h_modulus_r;
   assign lead_cam = (h_cycle_r == `CES_ZERO32) ? lead_r :
                     lead_r % h_cycle_r;

   // Engage point detection per held mode
   assign point_hit =
      (h_mode_r == `CES_EM_REL)  ? (lead_r == target_r) :
      (h_mode_r == `CES_EM_ABS)  ? (lead_r == h_point_r) :
      (h_mode_r == `CES_EM_AXPH) ? (armed_r &&
                                   lead_mod == h_point_r) :
                                   (lead_cam == h_point_r);

   // Cam relation: follower phase equals scaled leader phase
   always @* begin
      lead_ph = h_labs_r ? lead_cam : (lead_r - lbase_r + h_lshift_r);
      fol_want = h_fabs_r ? (lead_ph * h_fratio_r + h_fshift_r) :
                 (lead_ph * h_fratio_r + fbase_r);
      err = fol_want - fol_pos;
      // Direction picks signs allowed for the correction
      case (h_dir_r)
         `CES_DIR_FWD:   tgt_vel = err[31] ? `CES_ZERO32 : err;
         `CES_DIR_REV:   tgt_vel = err[31] ? err : `CES_ZERO32;
         default:        tgt_vel = err;
      endcase
   end

   // Relative mode with a zero point ramps at once; other starts stop, then wait or fault
   assign direct    = (mode_r[1:0] == `CES_EM_REL) &&
                      (point_r == `CES_ZERO32);
   assign ramp_halt = start && !direct;
   assign ramp_run = state_r[2] || state_r[3];

   // Follower motion within the held limits
   ces_ramp u_ramp (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .tick_i    (1'b1),
      .run_i     (ramp_run),
      .halt_i    (ramp_halt || state_r[1]),
      .tgt_vel_i (tgt_vel),
      .acc_lim_i (h_alim_r),
      .dec_lim_i (h_dlim_r),
      .vel_lim_i (h_vlim_r),
      .vel_o     (fol_vel),
      .pos_o     (fol_pos)
   );

   // Sequencer next state; any start, first or repeated, decides alone
   always @* begin
      state_nxt = state_r;
      if (start) begin
         if (mode_r[1:0] == `CES_EM_AXPH && point_r >= modulus_r)
            state_nxt = ST_ERR;
         else if (direct)
            state_nxt = ST_ENG;
         else
            state_nxt = ST_WAIT;
      end else begin
         case (state_r)
            ST_WAIT: begin
               if (point_hit)
                  state_nxt = ST_ENG;
            end
            // The step under way lands on the relation: phases match
            ST_ENG: begin
               if (err == fol_vel)
                  state_nxt = ST_SYNC;
            end
            ST_IDLE, ST_SYNC, ST_ERR: state_nxt = state_r;
            default: state_nxt = ST_IDLE;
         endcase
      end
   end

   // Sequencer state, held copies and status outputs
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r        <= ST_IDLE;
         h_mode_r       <= `CES_EM_REL;
         h_dir_r        <= `CES_DIR_SHORT;
         h_point_r      <= `CES_ZERO32;
         h_vlim_r       <= `CES_ZERO32;
         h_alim_r       <= `CES_ZERO32;
         h_dlim_r       <= `CES_ZERO32;
         h_modulus_r    <= `CES_ZERO32;
         h_cycle_r      <= `CES_ZERO32;
         h_labs_r       <= 1'b0;
         h_fabs_r       <= 1'b0;
         h_lshift_r     <= `CES_ZERO32;
         h_fshift_r     <= `CES_ZERO32;
         h_lratio_r     <= `CES_ONE32;
         h_fratio_r     <= `CES_ONE32;
         target_r       <= `CES_ZERO32;
         armed_r        <= 1'b0;
         lbase_r        <= `CES_ZERO32;
         fbase_r        <= `CES_ZERO32;
         busy_o         <= 1'b0;
         active_o       <= 1'b0;
         aborted_flag_o <= 1'b0;
         error_o        <= 1'b0;
         fault_code_o   <= `CES_FC_NONE;
         profile_done_o <= 1'b0;
         locked_flag_o  <= 1'b0;
         follower_pos_o <= `CES_POS_RESET;
      end else begin
         state_r        <= state_nxt;
         follower_pos_o <= fol_pos;
         if (start) begin
            // Take every command input at the start
            h_mode_r    <= mode_r[1:0];
            h_dir_r     <= mode_r[5:4];
            h_point_r   <= point_r;
            h_vlim_r    <= vlim_r;
            h_alim_r    <= alim_r;
            h_dlim_r    <= dlim_r;
            h_modulus_r <= modulus_r;
            h_cycle_r   <= cycle_r;
            h_labs_r    <= mode_r[`CES_MODE_LABS_BIT];
            h_fabs_r    <= mode_r[`CES_MODE_FABS_BIT];
            h_lshift_r  <= lshift_r;
            h_fshift_r  <= fshift_r;
            h_lratio_r  <= lratio_r;
            h_fratio_r  <= fratio_r;
            target_r    <= lead_r + point_r;
            // An axis phase match present at start is not taken
            armed_r     <= 1'b0;
            aborted_flag_o <= busy_o;
            error_o        <= 1'b0;
            fault_code_o   <= `CES_FC_NONE;
            profile_done_o <= 1'b0;
            locked_flag_o  <= 1'b0;
         end else if (state_r[1] && lead_mod != h_point_r) begin
            armed_r <= 1'b1;
         end
         if (state_nxt[2] && (!state_r[2] || start)) begin
            // Relation between positions and phases set now
            lbase_r <= lead_r;
            fbase_r <= fol_pos;
         end
         if (state_nxt[4] && start) begin
            error_o      <= 1'b1;
            fault_code_o <= `CES_FC_RANGE;
         end
         busy_o   <= state_nxt[1] || state_nxt[2] ||
                     state_nxt[3];
         active_o <= state_nxt[2] || state_nxt[3];
         if (state_nxt[3])
            locked_flag_o <= 1'b1;
         if (state_r[3] && lead_cam == h_cycle_r - `CES_STEP_ONE)
            profile_done_o <= 1'b1;
      end
   end

   // APB register writes, zero wait states
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_r    <= `CES_ZERO32;
         mode_r    <= `CES_ZERO32;
         point_r   <= `CES_ZERO32;
         vlim_r    <= `CES_ZERO32;
         alim_r    <= `CES_ZERO32;
         dlim_r    <= `CES_ZERO32;
         modulus_r <= `CES_ZERO32;
         cycle_r   <= `CES_ZERO32;
         lshift_r  <= `CES_ZERO32;
         fshift_r  <= `CES_ZERO32;
         lratio_r  <= `CES_ONE32;
         fratio_r  <= `CES_ONE32;
      end else if (apb_wr) begin
         case (paddr)
            `CES_CTRL_ADDR:    ctrl_r    <= pwdata;
            `CES_MODE_ADDR:    mode_r    <= pwdata;
            `CES_POINT_ADDR:   point_r   <= pwdata;
            `CES_VLIM_ADDR:    vlim_r    <= pwdata;
            `CES_ALIM_ADDR:    alim_r    <= pwdata;
            `CES_DLIM_ADDR:    dlim_r    <= pwdata;
            `CES_MODULUS_ADDR: modulus_r <= pwdata;
            `CES_CYCLE_ADDR:   cycle_r   <= pwdata;
            `CES_LSHIFT_ADDR:  lshift_r  <= pwdata;
            `CES_FSHIFT_ADDR:  fshift_r  <= pwdata;
            `CES_LRATIO_ADDR:  lratio_r  <= pwdata;
            `CES_FRATIO_ADDR:  fratio_r  <= pwdata;
            default:           ctrl_r    <= ctrl_r;
         endcase
      end
   end

   // APB read data, ready and error answered in the access cycle
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata  <= `CES_ZERO32;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            case (paddr)
               `CES_CTRL_ADDR:    prdata <= ctrl_r;
               `CES_MODE_ADDR:    prdata <= mode_r;
               `CES_POINT_ADDR:   prdata <= point_r;
               `CES_VLIM_ADDR:    prdata <= vlim_r;
               `CES_ALIM_ADDR:    prdata <= alim_r;
               `CES_DLIM_ADDR:    prdata <= dlim_r;
               `CES_MODULUS_ADDR: prdata <= modulus_r;
               `CES_CYCLE_ADDR:   prdata <= cycle_r;
               `CES_LSHIFT_ADDR:  prdata <= lshift_r;
               `CES_FSHIFT_ADDR:  prdata <= fshift_r;
               `CES_LRATIO_ADDR:  prdata <= lratio_r;
               `CES_FRATIO_ADDR:  prdata <= fratio_r;
               `CES_STATUS_ADDR:  prdata <= {25'h0, locked_flag_o,
                  profile_done_o, error_o, aborted_flag_o, active_o,
                  busy_o, state_r[1]};
               `CES_FAULT_ADDR:   prdata <= {16'h0, fault_code_o};
               `CES_LPOS_ADDR:    prdata <= lead_r;
               `CES_FPOS_ADDR:    prdata <= fol_pos;
               default: begin
                  prdata  <= `CES_ZERO32;
                  pslverr <= !apb_rd || 1'b1;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

//--- include/ces_regs.vh
// Purpose: Register map, field codes and reset values of the cam engage
//          sequencer.
// Assumes: 32-bit APB data, one register to an aligned word.
// Notes:   Definitions only.
`ifndef CES_REGS_VH
`define CES_REGS_VH

// Register byte offsets
`define CES_CTRL_ADDR      12'h000
`define CES_MODE_ADDR      12'h004
`define CES_POINT_ADDR     12'h008
`define CES_VLIM_ADDR      12'h00c
`define CES_ALIM_ADDR      12'h010
`define CES_DLIM_ADDR      12'h014
`define CES_MODULUS_ADDR   12'h018
`define CES_CYCLE_ADDR     12'h01c
`define CES_LSHIFT_ADDR    12'h020
`define CES_FSHIFT_ADDR    12'h024
`define CES_LRATIO_ADDR    12'h028
`define CES_FRATIO_ADDR    12'h02c
`define CES_STATUS_ADDR    12'h030
`define CES_FAULT_ADDR     12'h034
`define CES_LPOS_ADDR      12'h038
`define CES_FPOS_ADDR      12'h03c

// Control register fields
`define CES_CTRL_EXEC_BIT  0
`define CES_CTRL_RETRG_BIT 1

// Mode register fields
`define CES_MODE_EMODE_LSB 0
`define CES_MODE_EDIR_LSB  4
`define CES_MODE_LABS_BIT  8
`define CES_MODE_FABS_BIT  9

// Engage modes
`define CES_EM_REL         2'h0
`define CES_EM_ABS         2'h1
`define CES_EM_AXPH        2'h2
`define CES_EM_CAMPH       2'h3

// Engage directions
`define CES_DIR_SHORT      2'h0
`define CES_DIR_FWD        2'h1
`define CES_DIR_REV        2'h2

// Fault codes
`define CES_FC_NONE        16'h0000
`define CES_FC_RANGE       16'h0001
`define CES_FC_LIMIT       16'h0002

// Reset values
`define CES_ZERO32         32'h0000_0000
`define CES_ONE32          32'h0000_0001
`define CES_POS_RESET      32'h0000_0000
`define CES_STEP_ONE       32'h0000_0001

`endif

//--- logic/ces_ramp.v
// Purpose: Follower velocity shaper: steps speed toward a target at bounded
//          acceleration and deceleration, then advances position.
// Assumes: One update per control-cycle enable.
// Notes:   Signed velocities, magnitudes clipped to the limit.
`include "ces_regs.vh"
`default_nettype none

module ces_ramp (
   // Clock and reset
   input  wire        sys_clk_i,
   input  wire        rst_n_i,
   // Control
   input  wire        tick_i,
   input  wire        run_i,
   input  wire        halt_i,
   input  wire [31:0] tgt_vel_i,
   input  wire [31:0] acc_lim_i,
   input  wire [31:0] dec_lim_i,
   input  wire [31:0] vel_lim_i,
   // State
   output reg  [31:0] vel_o,
   output reg  [31:0] pos_o
);

   reg  [31:0] clip_tgt;
   reg  [31:0] vel_nxt;
   wire [31:0] neg_lim;
   wire        speeding_up;

   assign neg_lim = `CES_ZERO32 - vel_lim_i;
   // Accelerating when velocity rises from zero or above, or falls from below zero
   assign speeding_up = ($signed(clip_tgt) > $signed(vel_o)) ?
                        !vel_o[31] : vel_o[31];

   // Target clipped into the velocity limit and next velocity
   always @* begin
      clip_tgt = tgt_vel_i;
      if ($signed(tgt_vel_i) > $signed(vel_lim_i))
         clip_tgt = vel_lim_i;
      else if ($signed(tgt_vel_i) < $signed(neg_lim))
         clip_tgt = neg_lim;
      vel_nxt = clip_tgt;
      if ($signed(clip_tgt) > $signed(vel_o)) begin
         if ($signed(clip_tgt - vel_o) >
             $signed(speeding_up ? acc_lim_i : dec_lim_i))
            vel_nxt = vel_o + (speeding_up ? acc_lim_i : dec_lim_i);
      end else if ($signed(vel_o - clip_tgt) >
                   $signed(speeding_up ? acc_lim_i : dec_lim_i)) begin
         vel_nxt = vel_o - (speeding_up ? acc_lim_i : dec_lim_i);
      end
   end

   // Velocity and position registers
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         vel_o <= `CES_ZERO32;
         pos_o <= `CES_POS_RESET;
      end else if (halt_i) begin
         vel_o <= `CES_ZERO32;   // Immediate stop
      end else if (tick_i && run_i) begin
         vel_o <= vel_nxt;
         pos_o <= pos_o + vel_nxt;
      end
   end

endmodule

`default_nettype wire

//--- sim/ces_top_checker.sv
// Purpose: Port assertions for the cam engage sequencer.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound to every ces_top instance below.
`include "ces_regs.vh"
`default_nettype none
module ces_checker (
   // Clock, reset and APB
   input wire logic        sys_clk_i,
   input wire logic        rst_n_i,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Status
   input wire logic        busy_o,
   input wire logic        active_o,
   input wire logic        aborted_flag_o,
   input wire logic        error_o,
   input wire logic [15:0] fault_code_o,
   input wire logic        profile_done_o,
   input wire logic        locked_flag_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Bus answers one cycle after setup, error only off the map
   property p_rdy; psel && !penable |=> pready; endproperty
   property p_acc; pready |-> psel && penable; endproperty
   property p_map; pready |-> pslverr == (paddr > 12'h03c); endproperty
   property p_zero; pready && pslverr && !pwrite |-> prdata == 32'h0;
   endproperty
   // Status relations
   property p_eidle; error_o |-> !busy_o; endproperty
   property p_ehold; error_o && $past(error_o) |-> $stable(fault_code_o);
   endproperty
   property p_ecode; error_o |-> fault_code_o != `CES_FC_NONE; endproperty
   property p_abusy; active_o |-> busy_o; endproperty
   property p_lock; locked_flag_o |-> active_o; endproperty
   property p_done; $rose(profile_done_o) |-> locked_flag_o; endproperty
   a_rdy: assert property (p_rdy)
      else $error("no ready after setup");
   a_acc: assert property (p_acc)
      else $error("ready outside access");
   a_map: assert property (p_map)
      else $error("slave error flag wrong");
   a_zero: assert property (p_zero)
      else $error("unmapped read not zero");
   a_eidle: assert property (p_eidle)
      else $error("busy with error");
   a_ehold: assert property (p_ehold)
      else $error("fault code moved");
   a_ecode: assert property (p_ecode)
      else $error("error without cause");
   a_abusy: assert property (p_abusy)
      else $error("active while idle");
   a_lock: assert property (p_lock)
      else $error("locked while inactive");
   a_done: assert property (p_done)
      else $error("profile end unlocked");
   c_lock: cover property ($rose(locked_flag_o));
   c_err: cover property ($rose(error_o));
   c_abort: cover property ($rose(aborted_flag_o));
endmodule

bind ces_top ces_checker i_chk (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .busy_o(busy_o),
   .active_o(active_o), .aborted_flag_o(aborted_flag_o),
   .error_o(error_o), .fault_code_o(fault_code_o),
   .profile_done_o(profile_done_o), .locked_flag_o(locked_flag_o));
`default_nettype wire

//--- sim/ces_leader_axis.sv
// Purpose: Leader axis model: a position that steps each control cycle.
// Assumes: Step of zero gives a still leader, one a slow steady one.
// Notes:   Load sets the position outright.
`default_nettype none
module ces_leader_axis (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        load_i,
   input  wire logic [31:0] load_pos_i,
   input  wire logic [31:0] step_i,
   output var  logic [31:0] pos_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Position integrator
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pos_o <= 32'h0;
      end else if (load_i) begin
         pos_o <= load_pos_i;
      end else begin
         pos_o <= pos_o + step_i;
      end
   end
endmodule
`default_nettype wire

//--- sim/tb_ces_top.sv
// Purpose: Self-checking bench for the cam engage sequencer.
// Assumes: APB master here, leader axis from the model.
// Notes:   Fixed seed; expectations come from the register constants.
`include "ces_regs.vh"
`default_nettype none
module tb_ces_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, psel, penable, pwrite, lload, e;
   logic        pready, pslverr, busy, act, abrt, err, done, lock;
   logic [11:0] paddr;
   logic [15:0] fcode;
   logic [31:0] pwdata, prdata, lval, lstep, lpos, fpos, q, lp;
   logic [31:0] x, l0, pt, ex, fp;
   logic signed [31:0] d, dp;
   logic [31:0] mds [4] = '{32'h0, 32'h11, 32'h22, 32'h113};
   logic [31:0] pts [3] = '{32'h40, 32'hffff_ffff, 32'h3f};
   int          miscompares, n_tests, lim_bad, seed, n, i, k, dn;

   ces_top i_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .leader_pos_i(lpos), .follower_pos_o(fpos), .busy_o(busy),
      .active_o(act), .aborted_flag_o(abrt), .error_o(err),
      .fault_code_o(fcode), .profile_done_o(done), .locked_flag_o(lock));
   ces_leader_axis i_lead (.sys_clk_i(clk), .rst_n_i(rst_n),
      .load_i(lload), .load_pos_i(lval), .step_i(lstep), .pos_o(lpos));

   // Clock
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end

   // Follower speed and speed change against the programmed limits
   always @(posedge clk) begin
      d = fpos - fp;
      if (rst_n && (d > 8 || d < -8 || d - dp > 2 || dp - d > 2)) lim_bad++;
      fp = fpos;
      dp = d;
   end

   task automatic check(input string nm, input logic [31:0] s, xp);
      n_tests++;
      if (s !== xp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, xp, s);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // One APB transfer; read data and error land in q and e
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] wd);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'h1 && k < 16);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
      if (k >= 16) begin
         miscompares++;
         finish_test();
      end
   endtask

   task automatic lead(input logic [31:0] p, s);
      lload <= 1'h1;
      lval <= p;
      lstep <= s;
      @(posedge clk);
      lload <= 1'h0;
   endtask

   // Waits up to lim cycles for the follower to move
   task automatic wait_move(input int lim);
      logic [31:0] f0;
      f0 = fpos;
      n = 0;
      while (fpos === f0 && n < lim) begin
         @(posedge clk);
         n++;
      end
      lp = lpos;
   endtask

   task automatic do_reset();
      rst_n <= 1'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
   endtask

   task automatic setup(input logic [31:0] md, p);
      apb(1'h1, `CES_MODE_ADDR, md);
      apb(1'h1, `CES_POINT_ADDR, p);
      apb(1'h1, `CES_VLIM_ADDR, 32'h8);
      apb(1'h1, `CES_ALIM_ADDR, 32'h2);
      apb(1'h1, `CES_DLIM_ADDR, 32'h2);
      apb(1'h1, `CES_MODULUS_ADDR, 32'h40);
      apb(1'h1, `CES_CYCLE_ADDR, 32'h32);
   endtask

   task automatic start(input logic [31:0] c);
      apb(1'h1, `CES_CTRL_ADDR, c);
   endtask

   initial begin
      {rst_n, psel, penable, pwrite, lload} = 5'h0;
      paddr = 12'h0;
      {pwdata, lval, lstep, fp, dp} = 160'h0;
      seed = 41552;
      do_reset();
      // Ratio reset values, read-back and places off the map
      apb(1'h0, `CES_LRATIO_ADDR, 32'h0);
      check("lead ratio", q, `CES_ONE32);
      apb(1'h0, `CES_FRATIO_ADDR, 32'h0);
      check("follow ratio", q, `CES_ONE32);
      x = $random(seed);
      apb(1'h1, `CES_POINT_ADDR, x);
      apb(1'h0, `CES_POINT_ADDR, 32'h0);
      check("point", q, x);
      apb(1'h0, 12'h040, 32'h0);
      check("unmapped data", q, 32'h0);
      check("unmapped read err", e, 1'h1);
      apb(1'h1, 12'h044, x);
      check("unmapped write", e, 1'h1);
      $display("test registers done");
      // Every engage mode waits for its own leader position
      for (i = 0; i < 4; i++) begin
         do_reset();
         x = 32'h14 + ($random(seed) & 32'h3f);
         l0 = 32'h40 + ($random(seed) & 32'hff);
         pt = (i == 1) ? l0 + x : x;
         ex = l0 + x;
         if (i == 2) begin
            pt = l0 % 32'h40;
            // Reverse leader meets the phase again one modulus lower
            ex = l0 - 32'h4a;
         end
         if (i == 3) begin
            l0 = l0 - l0 % 32'h32 + 32'h14;
            pt = 32'ha;
            ex = l0 + 32'h28;
         end
         lead(l0, 32'h0);
         setup(mds[i], pt);
         start(32'h1);
         wait_move(20);
         check("held still", n, 20);
         lead(lpos, (i == 2) ? 32'hffff_ffff : 32'h1);
         wait_move(300);
         check("engage", lp >= ex && lp <= ex + 10, 1'h1);
         if (i == 1 || i == 3) check("fwd", $signed(fpos) > 0, 1'h1);
         if (i == 2) check("rev", $signed(fpos) < 0, 1'h1);
         if (i == 1) begin
            n = 0;
            while (lock !== 1'h1 && n < 3000) begin
               @(posedge clk);
               n++;
            end
            check("locked", lock, 1'h1);
            k = 0;
            dn = 0;
            repeat (60) begin
               @(posedge clk);
               k += lock;
               dn |= done;
            end
            check("stays locked", k, 60);
            check("profile end", dn, 1);
         end
         $display("test mode %0d done", i);
      end
      // Relative point zero ramps at once
      do_reset();
      lead(32'h12c, 32'h1);
      setup(32'h0, 32'h0);
      start(32'h1);
      wait_move(20);
      check("ramp at once", n < 20, 1'h1);
      $display("test ramp done");
      // Falling execute, held copies and restart while waiting
      do_reset();
      lead(32'h1f4, 32'h0);
      setup(32'h1, 32'h384);
      start(32'h1);
      start(32'h0);
      apb(1'h1, `CES_POINT_ADDR, 32'h1f4);
      wait_move(20);
      check("falling edge", busy, 1'h1);
      check("held copy", n, 20);
      start(32'h1);
      repeat (3) @(posedge clk);
      check("aborted", abrt, 1'h1);
      check("restart busy", busy, 1'h1);
      check("engage at once", act, 1'h1);
      $display("test retrigger done");
      // Axis phase point range, error and re-arming
      do_reset();
      lead(32'h0, 32'h0);
      for (i = 0; i < 3; i++) begin
         setup(32'h2, pts[i]);
         start(32'h0);
         start(32'h1);
         repeat (3) @(posedge clk);
         check("range error", err, i < 2);
         check("fault", fcode, (i < 2) ? `CES_FC_RANGE : `CES_FC_NONE);
         check("busy", busy, i == 2);
         if (i == 0) begin
            apb(1'h1, `CES_POINT_ADDR, 32'h3f);
            start(32'h1);
            repeat (3) @(posedge clk);
            check("level only", {err, busy}, 2'h2);
         end
      end
      $display("test range done");
      check("limits", lim_bad, 0);
      finish_test();
   end
endmodule
`default_nettype wire
